// File: hdl/sdt_debug_map.vh
// constants for the single-wire debug trace and tag port
`ifndef SDT_DEBUG_MAP_VH
`define SDT_DEBUG_MAP_VH
// ****************************************
// serial timing in debug serial clock cycles
// ****************************************
`define SDT_SYNC_MIN_LOW     10'h080
`define SDT_BIT_TIMEOUT      10'h200
`define SDT_SYNC_DELAY       10'h010
`define SDT_SYNC_PULSE       10'h080
// ****************************************
// tag codes, high then low
// ****************************************
`define SDT_TAG_NONE         2'h3
`define SDT_TAG_LOW          2'h2
`define SDT_TAG_HIGH         2'h1
`define SDT_TAG_BOTH         2'h0
`define SDT_TAG_BIT_HI       1
`define SDT_TAG_BIT_LO       0
`endif

// File: hdl/sdt_tag_queue.v
// instruction queue side-band that carries tag marks with program words
`timescale 1ns/1ps
module sdt_tag_queue (
    input  wire       clk_sys,
    input  wire       arst_n,
    input  wire       flush,
    input  wire       word_load,
    input  wire [1:0] word_tag,
    input  wire       head_advance,
    output wire       head_tagged
);
    // ****************************************
    // three stage tag pipe alongside the queue
    // ****************************************
    reg [1:0] stage0_ff;
    reg [1:0] stage1_ff;
    reg [1:0] stage2_ff;
    reg [1:0] nxt_stage0;
    reg [1:0] nxt_stage1;
    reg [1:0] nxt_stage2;

    // shift on load or advance, tag follows its word
    always @* begin
        nxt_stage0 = stage0_ff;
        nxt_stage1 = stage1_ff;
        nxt_stage2 = stage2_ff;
        if (flush) begin
            nxt_stage0 = 2'h0;
            nxt_stage1 = 2'h0;
            nxt_stage2 = 2'h0;
        end else if (word_load || head_advance) begin
            nxt_stage2 = stage1_ff;
            nxt_stage1 = stage0_ff;
            nxt_stage0 = word_load ? word_tag : 2'h0;
        end
    end

    // state
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stage0_ff <= 2'h0;
            stage1_ff <= 2'h0;
            stage2_ff <= 2'h0;
        end else begin
            stage0_ff <= nxt_stage0;
            stage1_ff <= nxt_stage1;
            stage2_ff <= nxt_stage2;
        end
    end

    // either byte tagged at head stops execution
    assign head_tagged = |stage2_ff;
endmodule

// File: hdl/sdt_debug_port.v
// single-wire debug port: serial time-out, sync reply, tagging, stepping
`timescale 1ns/1ps
`include "sdt_debug_map.vh"
module sdt_debug_port (
    input  wire       clk_sys,
    input  wire       arst_n,
    input  wire       debug_serial_clock,
    input  wire       debug_serial_pin_in,
    output reg        debug_serial_pin_out,
    output reg        debug_serial_pin_oe,
    input  wire       low_byte_strobe_in,
    input  wire       low_byte_strobe_en,
    input  wire       external_bus_clock,
    input  wire       cmd_valid,
    input  wire       cmd_single_step,
    input  wire       cmd_tag_and_go,
    input  wire       cmd_ack_enable,
    input  wire       cmd_ack_disable,
    input  wire       cmd_is_read,
    input  wire       transfer_done,
    input  wire       read_data_ready,
    input  wire       ack_issued,
    input  wire       irq_pending,
    input  wire       insn_done,
    input  wire       stack_done,
    input  wire       queue_load,
    input  wire       queue_advance,
    input  wire       wait_wake,
    input  wire       stop_wake,
    output reg        background_debug_mode,
    output reg        tagging_active,
    output reg        ack_enabled,
    output reg        run_user,
    output reg        stack_only,
    output wire       cmd_accept,
    output reg        soft_reset,
    output reg        sync_seen,
    output reg        bit_valid,
    output reg        bit_value,
    output reg        read_pending
);
    // ****************************************
    // pin synchronisers, three flops
    // ****************************************
    reg [2:0] pin_sync_ff;
    reg [2:0] low_byte_strobe_sync_ff;
    reg [2:0] external_bus_clock_sync_ff;
    reg [2:0] bdc_sync_ff;
    reg       pin_ff;
    reg       external_bus_clock_ff;
    reg       bdc_ff;

    // except on the low byte strobe, second and third must agree before a change counts
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_sync_ff   <= 3'h7;
            low_byte_strobe_sync_ff <= 3'h7;
            external_bus_clock_sync_ff  <= 3'h0;
            bdc_sync_ff   <= 3'h0;
            pin_ff        <= 1'b1;
            external_bus_clock_ff       <= 1'b0;
            bdc_ff        <= 1'b0;
        end else begin
            pin_sync_ff   <= {pin_sync_ff[1:0], debug_serial_pin_in};
            low_byte_strobe_sync_ff <= {low_byte_strobe_sync_ff[1:0], low_byte_strobe_in};
            external_bus_clock_sync_ff  <= {external_bus_clock_sync_ff[1:0], external_bus_clock};
            bdc_sync_ff   <= {bdc_sync_ff[1:0], debug_serial_clock};
            if (pin_sync_ff[1] == pin_sync_ff[2])
                pin_ff <= pin_sync_ff[2];
            if (external_bus_clock_sync_ff[1] == external_bus_clock_sync_ff[2])
                external_bus_clock_ff <= external_bus_clock_sync_ff[2];
            if (bdc_sync_ff[1] == bdc_sync_ff[2])
                bdc_ff <= bdc_sync_ff[2];
        end
    end

    // ****************************************
    // edge detection
    // ****************************************
    reg  pin_q_ff;
    reg  external_bus_clock_q_ff;
    reg  bdc_q_ff;
    wire pin_fall  = pin_q_ff & ~pin_ff;
    wire pin_rise  = ~pin_q_ff & pin_ff;
    wire external_bus_clock_fall = external_bus_clock_q_ff & ~external_bus_clock_ff;
    wire bdc_tick  = ~bdc_q_ff & bdc_ff; // serial clock enable

    // delayed copies
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_q_ff  <= 1'b1;
            external_bus_clock_q_ff <= 1'b0;
            bdc_q_ff  <= 1'b0;
        end else begin
            pin_q_ff  <= pin_ff;
            external_bus_clock_q_ff <= external_bus_clock_ff;
            bdc_q_ff  <= bdc_ff;
        end
    end

    // saturating increment used by all counters
    function [9:0] sat_inc;
        input [9:0] v;
        begin
            sat_inc = (v == 10'h3ff) ? v : v + 10'h001;
        end
    endfunction

    // ****************************************
    // serial receive state machine
    // ****************************************
    localparam [2:0] S_IDLE   = 3'h0;
    localparam [2:0] S_LOW    = 3'h1;
    localparam [2:0] S_GAP    = 3'h2;
    localparam [2:0] S_SWAIT  = 3'h3;
    localparam [2:0] S_SDLY   = 3'h4;
    localparam [2:0] S_SPULSE = 3'h5;
    localparam [2:0] S_SPEED  = 3'h6;

    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [9:0] cnt_ff;
    reg [9:0] nxt_cnt;
    reg       busy_ff;
    reg       nxt_busy;
    reg       ack_armed_ff;
    reg       nxt_ack_armed;
    reg       nxt_pin_out;
    reg       nxt_pin_oe;
    reg       nxt_soft_reset;
    reg       nxt_sync_seen;
    reg       nxt_bit_valid;
    reg       nxt_bit_value;
    reg       nxt_read_pending;
    wire      wake = wait_wake | stop_wake;
    // read wait is exempt only while handshake on and not yet acknowledged
    wire      timeout_hold = read_pending & ack_enabled & ~ack_armed_ff;
    wire      busy_any = busy_ff | read_pending;

    // next state and outputs of the serial engine
    always @* begin
        nxt_state        = state_ff;
        nxt_cnt          = cnt_ff;
        nxt_busy         = busy_ff;
        nxt_ack_armed    = ack_armed_ff;
        nxt_pin_out      = 1'b0;
        nxt_pin_oe       = 1'b0;
        nxt_soft_reset   = 1'b0;
        nxt_sync_seen    = 1'b0;
        nxt_bit_valid    = 1'b0;
        nxt_bit_value    = 1'b0;
        nxt_read_pending = read_pending;
        if (cmd_valid && cmd_is_read)
            nxt_read_pending = 1'b1;
        if (read_pending && ack_issued)
            nxt_ack_armed = 1'b1;
        if (cmd_valid && !cmd_is_read)
            nxt_busy = 1'b0;
        if (transfer_done) begin
            nxt_busy         = 1'b0;
            nxt_cnt          = 10'h000;
            nxt_read_pending = 1'b0;
            nxt_ack_armed    = 1'b0;
        end
        case (state_ff)
            S_IDLE: begin
                if (pin_fall && !tagging_active) begin
                    nxt_state = S_LOW;
                    nxt_cnt   = 10'h000;
                end else if (busy_any && !timeout_hold && bdc_tick) begin
                    nxt_cnt = sat_inc(cnt_ff);
                    if (cnt_ff >= `SDT_BIT_TIMEOUT - 10'h001) begin
                        nxt_soft_reset = 1'b1;
                        nxt_cnt        = 10'h000;
                    end
                end
            end
            S_LOW: begin
                if (pin_rise) begin
                    nxt_state     = S_GAP;
                    nxt_bit_valid = 1'b1;
                    nxt_bit_value = (cnt_ff < `SDT_SYNC_MIN_LOW >> 1);
                    nxt_busy      = 1'b1;
                end else if (bdc_tick) begin
                    nxt_cnt = sat_inc(cnt_ff);
                    if (cnt_ff >= `SDT_SYNC_MIN_LOW) begin
                        nxt_state      = S_SWAIT;
                        nxt_sync_seen  = 1'b1;
                        nxt_soft_reset = 1'b1;
                    end
                end
            end
            S_GAP: begin
                if (pin_fall) begin
                    nxt_state = S_LOW;
                    nxt_cnt   = 10'h000;
                end else if (bdc_tick) begin
                    nxt_cnt = sat_inc(cnt_ff);
                    if (cnt_ff >= `SDT_BIT_TIMEOUT - 10'h001) begin
                        nxt_state      = S_IDLE;
                        nxt_soft_reset = 1'b1;
                    end
                end else if (!busy_ff) begin
                    nxt_state = S_IDLE;
                    nxt_cnt   = 10'h000;
                end
            end
            S_SWAIT: begin
                if (pin_rise) begin
                    nxt_state = S_SDLY;
                    nxt_cnt   = 10'h000;
                end
            end
            S_SDLY: begin
                if (bdc_tick) begin
                    nxt_cnt = sat_inc(cnt_ff);
                    if (cnt_ff >= `SDT_SYNC_DELAY - 10'h001) begin
                        nxt_state = S_SPULSE;
                        nxt_cnt   = 10'h000;
                    end
                end
            end
            S_SPULSE: begin
                nxt_pin_oe = 1'b1;
                if (bdc_tick) begin
                    nxt_cnt = sat_inc(cnt_ff);
                    if (cnt_ff >= `SDT_SYNC_PULSE - 10'h001)
                        nxt_state = S_SPEED;
                end
            end
            S_SPEED: begin
                nxt_pin_oe  = 1'b1;
                nxt_pin_out = 1'b1;
                if (bdc_tick) begin
                    nxt_state = S_IDLE;
                    nxt_pin_oe = 1'b0;
                    nxt_cnt   = 10'h000;
                end
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
        if (nxt_soft_reset) begin
            nxt_busy         = 1'b0;
            nxt_cnt          = 10'h000;
            nxt_read_pending = 1'b0;
            nxt_ack_armed    = 1'b0;
        end
        if (wake) begin
            nxt_state        = S_IDLE;
            nxt_cnt          = 10'h000;
            nxt_soft_reset   = 1'b1;
            nxt_busy         = 1'b0;
            nxt_read_pending = 1'b0;
            nxt_ack_armed    = 1'b0;
            nxt_pin_oe       = 1'b0;
            nxt_pin_out      = 1'b0;
        end
    end

    // serial engine registers
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_ff             <= S_IDLE;
            cnt_ff               <= 10'h000;
            busy_ff              <= 1'b0;
            ack_armed_ff         <= 1'b0;
            debug_serial_pin_out <= 1'b0;
            debug_serial_pin_oe  <= 1'b0;
            soft_reset           <= 1'b0;
            sync_seen            <= 1'b0;
            bit_valid            <= 1'b0;
            bit_value            <= 1'b0;
            read_pending         <= 1'b0;
        end else begin
            state_ff             <= nxt_state;
            cnt_ff               <= nxt_cnt;
            busy_ff              <= nxt_busy;
            ack_armed_ff         <= nxt_ack_armed;
            debug_serial_pin_out <= nxt_pin_out;
            debug_serial_pin_oe  <= nxt_pin_oe;
            soft_reset           <= nxt_soft_reset;
            sync_seen            <= nxt_sync_seen;
            bit_valid            <= nxt_bit_valid;
            bit_value            <= nxt_bit_value;
            read_pending         <= nxt_read_pending;
        end
    end

    // ****************************************
    // tag sampling and queue
    // ****************************************
    reg  [1:0] tag_ff;
    wire       head_tagged;

    // each pin sampled on bus clock fall, low means tag
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tag_ff <= `SDT_TAG_NONE;
        end else if (external_bus_clock_fall) begin
            tag_ff[`SDT_TAG_BIT_HI] <= pin_ff;
            tag_ff[`SDT_TAG_BIT_LO] <= low_byte_strobe_sync_ff[2] | ~low_byte_strobe_en;
        end
    end

    // tag decode into byte marks
    function [1:0] tag_marks;
        input [1:0] code;
        begin
            case (code)
                `SDT_TAG_LOW:  tag_marks = 2'h1;
                `SDT_TAG_HIGH: tag_marks = 2'h2;
                `SDT_TAG_BOTH: tag_marks = 2'h3;
                default:       tag_marks = 2'h0;
            endcase
        end
    endfunction

    sdt_tag_queue u_tag_queue (
        .clk_sys      (clk_sys),
        .arst_n       (arst_n),
        .flush        (background_debug_mode),
        .word_load    (queue_load),
        .word_tag     (tagging_active ? tag_marks(tag_ff) : 2'h0),
        .head_advance (queue_advance),
        .head_tagged  (head_tagged)
    );

    // ****************************************
    // debug mode, stepping and acknowledge control
    // ****************************************
    reg nxt_bdm;
    reg nxt_tagging;
    reg nxt_ack_en;
    reg nxt_run;
    reg nxt_stack;

    // commands accepted whenever not tagging; step and tag-and-go also need debug mode
    assign cmd_accept = cmd_valid & ~tagging_active;

    // mode transitions
    always @* begin
        nxt_bdm     = background_debug_mode;
        nxt_tagging = tagging_active;
        nxt_ack_en  = ack_enabled;
        nxt_run     = run_user;
        nxt_stack   = stack_only;
        if (cmd_accept && cmd_ack_enable)
            nxt_ack_en = 1'b1;
        if (cmd_accept && cmd_ack_disable)
            nxt_ack_en = 1'b0;
        if (cmd_accept && cmd_tag_and_go && background_debug_mode) begin
            nxt_bdm     = 1'b0;
            nxt_tagging = 1'b1;
        end
        if (cmd_accept && cmd_single_step && background_debug_mode) begin
            nxt_bdm = 1'b0;
            if (irq_pending)
                nxt_stack = 1'b1;
            else
                nxt_run = 1'b1;
        end
        if ((run_user && insn_done) || (stack_only && stack_done)) begin
            nxt_bdm   = 1'b1;
            nxt_run   = 1'b0;
            nxt_stack = 1'b0;
        end
        if (tagging_active && head_tagged) begin
            nxt_bdm = 1'b1;
        end
        if (nxt_bdm)
            nxt_tagging = 1'b0;
        if (wake)
            nxt_ack_en = 1'b0;
    end

    // mode registers, acknowledge off from reset
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            background_debug_mode <= 1'b1;
            tagging_active        <= 1'b0;
            ack_enabled           <= 1'b0;
            run_user              <= 1'b0;
            stack_only            <= 1'b0;
        end else begin
            background_debug_mode <= nxt_bdm;
            tagging_active        <= nxt_tagging;
            ack_enabled           <= nxt_ack_en;
            run_user              <= nxt_run;
            stack_only            <= nxt_stack;
        end
    end
endmodule

// File: dv/sdt_debug_port_checker.sv
// concurrent checks on the ports of the single-wire debug port
`timescale 1ns/1ps
module sdt_debug_port_checker (
    input logic clk_sys,
    input logic arst_n,
    input logic cmd_valid,
    input logic cmd_single_step,
    input logic cmd_tag_and_go,
    input logic irq_pending,
    input logic wait_wake,
    input logic stop_wake,
    input logic background_debug_mode,
    input logic tagging_active,
    input logic ack_enabled,
    input logic run_user,
    input logic stack_only,
    input logic cmd_accept,
    input logic soft_reset,
    input logic sync_seen,
    input logic bit_valid,
    input logic debug_serial_pin_out,
    input logic debug_serial_pin_oe,
    input logic read_pending
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    // ****************************************
    // assertions
    // ****************************************
    a_accept_gate: assert property (cmd_accept == (cmd_valid && !tagging_active))
        else $error("command taken while tagging");
    a_entry_stops_tag: assert property ($rose(background_debug_mode) |-> !tagging_active)
        else $error("tagging left on at debug entry");
    a_tag_cause: assert property ($rose(tagging_active) |-> $past(cmd_valid) && $past(cmd_tag_and_go))
        else $error("tagging started without tag-and-go");
    a_step_single: assert property (cmd_valid && cmd_single_step && background_debug_mode && !tagging_active
        |=> (run_user != stack_only) && (stack_only == $past(irq_pending)))
        else $error("single step did not pick one action");
    a_wake_clears: assert property (wait_wake || stop_wake |=> soft_reset && !ack_enabled)
        else $error("wake did not clear the port");
    a_sync_discards: assert property (sync_seen |-> soft_reset)
        else $error("sync request kept partial transfer");
    a_bit_pulse: assert property (bit_valid |-> !sync_seen ##1 !bit_valid)
        else $error("bit strobe too long or mixed with sync");
    a_pin_free_tag: assert property (debug_serial_pin_oe |-> !tagging_active)
        else $error("pin driven while used as tag input");
    a_reply_low: assert property ($rose(debug_serial_pin_oe) |-> !debug_serial_pin_out ##1
        (debug_serial_pin_oe && !debug_serial_pin_out) [*8])
        else $error("sync reply does not start low");
    // ****************************************
    // covers
    // ****************************************
    c_sync: cover property (sync_seen);
    c_read_hs: cover property ($rose(read_pending) && ack_enabled);
    c_wake: cover property (wait_wake ##1 soft_reset);
endmodule

// File: dv/sdt_host_pod.sv
// behavioural debug host on the single-wire pin
`timescale 1ns/1ps
module sdt_host_pod (
    input  wire sclk,
    input  wire dev_oe,
    input  wire dev_out,
    output wire pin_level
);
    reg  drive_low_ff = 1'b0;
    time t_fall       = 0;
    time t_rise       = 0;
    // pulled-up wire: device drive wins, else host low, else high
    assign pin_level = dev_oe ? dev_out : !drive_low_ff;
    // every host transfer opens with a falling edge
    task fall;
        begin
            @(posedge sclk);
            #3 drive_low_ff = 1'b1;
            t_fall = $time;
        end
    endtask
    // release, pull-up returns the wire high
    task rise;
        begin
            @(posedge sclk);
            #3 drive_low_ff = 1'b0;
            t_rise = $time;
        end
    endtask
    // short low pulse read as one bit
    task send_bit(input int n);
        begin
            fall();
            repeat (n) @(posedge sclk);
            rise();
        end
    endtask
endmodule

// File: dv/test_single_wire_debug_trace_tag.sv
// self-checking bench for the single-wire debug port
`timescale 1ns/1ps
module test_single_wire_debug_trace_tag;
    localparam int SCLK_NS = 200;
    reg       clk_sys, arst_n, sclk, external_bus_clock, low_byte_strobe_in, queue_load;
    reg       cmd_valid, cmd_single_step, cmd_tag_and_go, cmd_ack_enable, cmd_ack_disable, cmd_is_read;
    reg       transfer_done, ack_issued, irq_pending, wait_wake, stop_wake, insn_done, stack_done;
    reg [1:0] bus_div;
    wire      pin_level, debug_serial_pin_out, debug_serial_pin_oe, background_debug_mode, tagging_active;
    wire      ack_enabled, run_user, stack_only, cmd_accept, soft_reset, sync_seen, bit_valid, bit_value;
    wire      read_pending;
    int       n_mismatch = 0;
    int       tests_run = 0;
    int       k;
    bit       hit;
    time      t0;

    sdt_debug_port u_sdt_debug_port (.clk_sys(clk_sys), .arst_n(arst_n), .debug_serial_clock(sclk),
        .debug_serial_pin_in(pin_level), .debug_serial_pin_out(debug_serial_pin_out),
        .debug_serial_pin_oe(debug_serial_pin_oe), .low_byte_strobe_in(low_byte_strobe_in),
        .low_byte_strobe_en(1'b1), .external_bus_clock(external_bus_clock), .cmd_valid(cmd_valid),
        .cmd_single_step(cmd_single_step), .cmd_tag_and_go(cmd_tag_and_go), .cmd_ack_enable(cmd_ack_enable),
        .cmd_ack_disable(cmd_ack_disable), .cmd_is_read(cmd_is_read), .transfer_done(transfer_done),
        .read_data_ready(1'b0), .ack_issued(ack_issued), .irq_pending(irq_pending), .insn_done(insn_done),
        .stack_done(stack_done), .queue_load(queue_load), .queue_advance(1'b0), .wait_wake(wait_wake),
        .stop_wake(stop_wake), .background_debug_mode(background_debug_mode), .tagging_active(tagging_active),
        .ack_enabled(ack_enabled), .run_user(run_user), .stack_only(stack_only), .cmd_accept(cmd_accept),
        .soft_reset(soft_reset), .sync_seen(sync_seen), .bit_valid(bit_valid), .bit_value(bit_value),
        .read_pending(read_pending));
    sdt_host_pod u_sdt_host_pod (.sclk(sclk), .dev_oe(debug_serial_pin_oe), .dev_out(debug_serial_pin_out),
        .pin_level(pin_level));

    // ****************************************
    // clocks and background stimulus
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        sclk = 1'b0;
        forever #100 sclk = ~sclk;
    end
    // bus clock, low tag pin and queue loads
    always @(posedge clk_sys) begin
        #2;
        bus_div = bus_div + 2'h1;
        external_bus_clock = bus_div[1];
        low_byte_strobe_in = &bus_div;
        queue_load = (bus_div == 2'h3);
    end

    // ****************************************
    // helpers
    // ****************************************
    task check(input logic [15:0] got, input logic [15:0] exp);
        begin
            tests_run++;
            if (got !== exp) begin
                n_mismatch++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task check_rng(input int v, input int lo, input int hi);
        begin
            tests_run++;
            if (v < lo || v > hi) begin
                n_mismatch++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, v, lo);
            end
        end
    endtask
    function int ticks(input time ts);
        ticks = int'(($time - ts) / SCLK_NS);
    endfunction
    function logic sel(input int which);
        case (which)
            0: sel = bit_valid;
            1: sel = soft_reset;
            2: sel = sync_seen;
            default: sel = debug_serial_pin_oe;
        endcase
    endfunction
    // bounded wait on an output
    task wait_on(input int which, input int lim, output bit h);
        int i;
        begin
            h = 1'b0;
            for (i = 0; i < lim && !h; i++) begin
                @(posedge clk_sys);
                #1;
                h = (sel(which) === 1'b1);
            end
        end
    endtask
    // one decoded command: {step, tag, ack on, ack off, read}
    task cmd(input logic [4:0] q);
        begin
            @(posedge clk_sys);
            #2 cmd_valid = 1'b1;
            {cmd_single_step, cmd_tag_and_go, cmd_ack_enable, cmd_ack_disable, cmd_is_read} = q;
            @(posedge clk_sys);
            #2 cmd_valid = 1'b0;
            {cmd_single_step, cmd_tag_and_go, cmd_ack_enable, cmd_ack_disable, cmd_is_read} = 5'h00;
        end
    endtask
    task results;
        begin
            if (n_mismatch == 0 && tests_run > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {cmd_valid, cmd_single_step, cmd_tag_and_go, cmd_ack_enable, cmd_ack_disable, cmd_is_read} = 6'h00;
        {transfer_done, ack_issued, irq_pending, wait_wake, stop_wake, insn_done, stack_done} = 7'h00;
        bus_div = 2'h0;
        arst_n = 1'b0;
        repeat (6) @(posedge clk_sys);
        #2 arst_n = 1'b1;
        repeat (5) @(posedge clk_sys);
        check({ack_enabled, debug_serial_pin_oe}, 2'h0);
        // short bit, then bit time-out
        u_sdt_host_pod.send_bit(10);
        wait_on(0, 100, hit);
        check({hit, bit_value}, 2'h3);
        wait_on(1, 4400, hit);
        check(hit, 1'b1);
        check_rng(ticks(u_sdt_host_pod.t_fall), 512, 514);
        // long low: sync request
        u_sdt_host_pod.fall();
        wait_on(2, 1200, hit);
        check({hit, soft_reset}, 2'h3);
        check_rng(ticks(u_sdt_host_pod.t_fall), 128, 130);
        repeat (600) @(posedge sclk);
        check(debug_serial_pin_oe, 1'b0);
        u_sdt_host_pod.rise();
        wait_on(3, 200, hit);
        check_rng(ticks(u_sdt_host_pod.t_rise), 16, 17);
        t0 = $time;
        while (debug_serial_pin_oe === 1'b1 && debug_serial_pin_out === 1'b0 && ticks(t0) < 200) begin
            @(posedge clk_sys);
            #1;
        end
        check_rng(ticks(t0), 127, 128);
        check({debug_serial_pin_oe, debug_serial_pin_out}, 2'h3);
        repeat (16) @(posedge clk_sys);
        check(debug_serial_pin_oe, 1'b0);
        // read time-out, handshake off then on
        for (k = 0; k < 2; k++) begin
            cmd(k ? 5'h04 : 5'h02);
            check(ack_enabled, k[0]);
            cmd(5'h01);
            t0 = $time;
            check(read_pending, 1'b1);
            wait_on(1, 4800, hit);
            check(hit, !k[0]);
            if (k == 0)
                check_rng(ticks(t0), 511, 513);
            @(posedge clk_sys);
            #1 check(read_pending, k[0]);
        end
        // acknowledge re-arms time-out
        #1 ack_issued = 1'b1;
        t0 = $time;
        @(posedge clk_sys);
        #2 ack_issued = 1'b0;
        wait_on(1, 4400, hit);
        check(hit, 1'b1);
        check_rng(ticks(t0), 511, 513);
        // finished transfer ends the pending read
        cmd(5'h01);
        @(posedge clk_sys);
        #2 transfer_done = 1'b1;
        @(posedge clk_sys);
        #2 transfer_done = 1'b0;
        check(read_pending, 1'b0);
        // wake from wait and stop
        for (k = 0; k < 2; k++) begin
            cmd(5'h04);
            @(posedge clk_sys);
            #2 {stop_wake, wait_wake} = k ? 2'h2 : 2'h1;
            @(posedge clk_sys);
            #1 check({soft_reset, ack_enabled}, 2'h2);
            #1 {stop_wake, wait_wake} = 2'h0;
        end
        // single step, then tag-and-go
        for (k = 0; k < 2; k++) begin
            irq_pending = !k[0];
            cmd(5'h10);
            check({run_user, stack_only, background_debug_mode}, k ? 3'h4 : 3'h2);
            #2 {insn_done, stack_done} = k ? 2'h2 : 2'h1;
            @(posedge clk_sys);
            #2 {insn_done, stack_done} = 2'h0;
        end
        cmd(5'h08);
        check({tagging_active, background_debug_mode}, 2'h2);
        repeat (24) @(posedge clk_sys);
        check({tagging_active, background_debug_mode}, 2'h1);
        results();
    end

    // watchdog
    initial begin
        #2000000;
        n_mismatch++;
        results();
    end
endmodule

bind sdt_debug_port sdt_debug_port_checker u_sdt_debug_port_checker (.clk_sys(clk_sys), .arst_n(arst_n),
    .cmd_valid(cmd_valid), .cmd_single_step(cmd_single_step), .cmd_tag_and_go(cmd_tag_and_go),
    .irq_pending(irq_pending), .wait_wake(wait_wake), .stop_wake(stop_wake),
    .background_debug_mode(background_debug_mode), .tagging_active(tagging_active), .ack_enabled(ack_enabled),
    .run_user(run_user), .stack_only(stack_only), .cmd_accept(cmd_accept), .soft_reset(soft_reset),
    .sync_seen(sync_seen), .bit_valid(bit_valid), .debug_serial_pin_out(debug_serial_pin_out),
    .debug_serial_pin_oe(debug_serial_pin_oe), .read_pending(read_pending));
